// ### rtl/audio_serial_consts.svh
// Constants for the audio serial port pin control block.
// Assumes inclusion by bare name from the package and the design files.
`ifndef AUDIO_SERIAL_CONSTS_SVH
`define AUDIO_SERIAL_CONSTS_SVH

// ----------------------------------------------------------------------
// Framing and clock generation
// ----------------------------------------------------------------------
`define AS_WORD_BITS  16
`define AS_CNT_W      5
`define AS_DIV_W      4
`define AS_DIV_LAST   4'h3
`define AS_WORD_LAST  5'h0f
`define AS_CNT_FULL   5'h10
`define AS_CNT_ONE    5'h01
`define AS_TX_IDLE    16'hffff

// ----------------------------------------------------------------------
// Sections and buffering
// ----------------------------------------------------------------------
`define AS_RX         0
`define AS_TX         1
`define AS_BUF_W      33
`define AS_BUF_DEPTH  2

`endif

// ### rtl/audio_serial_pkg.sv
// Types shared by the audio serial port design files.
// Assumes the constants header is on the include path.
`include "audio_serial_consts.svh"

package audio_serial_pkg;

    typedef logic [`AS_WORD_BITS-1:0] sample_type;
    typedef logic [`AS_CNT_W-1:0]     bit_cnt_type;
    typedef logic [`AS_DIV_W-1:0]     div_cnt_type;

endpackage : audio_serial_pkg

// ### rtl/sample_buffer.sv
// Small FIFO of flip-flops with valid and ready on both sides.
// Assumes one clock domain and that flush is a synchronous level.
`include "audio_serial_consts.svh"

module sample_buffer #(
    parameter int WIDTH = `AS_BUF_W,
    parameter int DEPTH = `AS_BUF_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW:0]   FULL = (PW+1)'(DEPTH);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_q;
    logic [PW-1:0]    rd_q;
    logic [PW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_q != FULL);
    assign out_valid = (cnt_q != '0);
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem_q[rd_q];

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // ------------------------------------------------------------------
    // Pointers and fill count
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else if (flush) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == LAST) ? '0 : wr_q + PW'(1);
            end
            if (pop) begin
                rd_q <= (rd_q == LAST) ? '0 : rd_q + PW'(1);
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + (PW+1)'(1);
            end else if (pop && !push) begin
                cnt_q <= cnt_q - (PW+1)'(1);
            end
        end
    end

endmodule // sample_buffer

// ### rtl/audio_serial_port.sv
// Pin control and serial framing for the audio serial port.
// Assumes pins are resolved outside from _o/_oe; _ie gates the input buffers.
`include "audio_serial_consts.svh"

module audio_serial_port
    import audio_serial_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic sw_reset,
    input  wire logic stop_state,
    input  wire logic rx_master,
    input  wire logic tx_master,
    input  wire logic rx0_enable_bit,
    input  wire logic rx1_enable_bit,
    input  wire logic tx0_enable_bit,
    input  wire logic tx1_enable_bit,
    input  wire logic tx2_enable_bit,
    input  wire logic rx_data_in_0_i,
    output logic      rx_data_in_0_ie,
    input  wire logic rx_data_in_1_i,
    output logic      rx_data_in_1_ie,
    input  wire logic rx_bit_clock_i,
    output logic      rx_bit_clock_o,
    output logic      rx_bit_clock_oe,
    output logic      rx_bit_clock_ie,
    input  wire logic rx_word_select_i,
    output logic      rx_word_select_o,
    output logic      rx_word_select_oe,
    output logic      rx_word_select_ie,
    output logic      tx_data_out_0,
    output logic      tx_data_out_1,
    output logic      tx_data_out_2,
    input  wire logic tx_bit_clock_i,
    output logic      tx_bit_clock_o,
    output logic      tx_bit_clock_oe,
    output logic      tx_bit_clock_ie,
    input  wire logic tx_word_select_i,
    output logic      tx_word_select_o,
    output logic      tx_word_select_oe,
    output logic      tx_word_select_ie,
    output sample_type rx_sample_0,
    output sample_type rx_sample_1,
    output logic      rx_right,
    output logic      rx_valid,
    input  wire logic rx_ready,
    output logic      rx_overrun,
    input  wire sample_type tx_sample,
    input  wire logic tx_valid,
    output logic      tx_ready,
    output logic      tx_underrun
);

    // ------------------------------------------------------------------
    // Section activity and pin enables
    // ------------------------------------------------------------------
    logic        blocked;
    logic [1:0]  mst;
    logic [1:0]  act_q;
    logic [1:0]  rx_dat_ie_q;
    logic [2:0]  tx_on_q;
    logic [1:0]  oe_q;
    logic [1:0]  bclk_pin;
    logic [1:0]  ws_pin;

    assign blocked  = sw_reset | stop_state;
    assign mst      = {tx_master, rx_master};
    assign bclk_pin = {tx_bit_clock_i, rx_bit_clock_i};
    assign ws_pin   = {tx_word_select_i, rx_word_select_i};

    // Enables are registered so every pin state comes from a flip-flop
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            act_q       <= 2'h0;
            rx_dat_ie_q <= 2'h0;
            tx_on_q     <= 3'h0;
            oe_q        <= 2'h0;
        end else begin
            act_q[`AS_RX] <= ~blocked & (rx0_enable_bit | rx1_enable_bit);
            act_q[`AS_TX] <= ~blocked & (tx0_enable_bit | tx1_enable_bit | tx2_enable_bit);
            rx_dat_ie_q   <= {~blocked & rx1_enable_bit, ~blocked & rx0_enable_bit};
            tx_on_q       <= {~blocked & tx2_enable_bit, ~blocked & tx1_enable_bit,
                              ~blocked & tx0_enable_bit};
            oe_q[`AS_RX]  <= ~blocked & (rx0_enable_bit | rx1_enable_bit) & rx_master;
            oe_q[`AS_TX]  <= ~blocked & (tx0_enable_bit | tx1_enable_bit | tx2_enable_bit)
                             & tx_master;
        end
    end

    assign rx_data_in_0_ie   = rx_dat_ie_q[0];
    assign rx_data_in_1_ie   = rx_dat_ie_q[1];
    assign rx_bit_clock_oe   = oe_q[`AS_RX];
    assign rx_word_select_oe = oe_q[`AS_RX];
    assign rx_bit_clock_ie   = act_q[`AS_RX];
    assign rx_word_select_ie = act_q[`AS_RX];
    assign tx_bit_clock_oe   = oe_q[`AS_TX];
    assign tx_word_select_oe = oe_q[`AS_TX];
    assign tx_bit_clock_ie   = act_q[`AS_TX];
    assign tx_word_select_ie = act_q[`AS_TX];

    // ------------------------------------------------------------------
    // Per-section clocking: master generator or synchronised pins
    // ------------------------------------------------------------------
    logic [1:0]  bclk_s1_q;
    logic [1:0]  bclk_s2_q;
    logic [1:0]  ws_s1_q;
    logic [1:0]  ws_s2_q;
    div_cnt_type div_q [2];
    bit_cnt_type mcnt_q [2];
    logic [1:0]  mbclk_q;
    logic [1:0]  mws_q;
    logic [1:0]  bclk_now;
    logic [1:0]  ws_now;
    logic [1:0]  bclk_prev_q;
    logic [1:0]  ws_last_q;
    logic [1:0]  rise;
    logic [1:0]  fall;
    logic [1:0]  start;

    for (genvar s = 0; s < 2; s++) begin : g_sect
        // Two flops ahead of any logic; the first feeds only the second
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                bclk_s1_q[s] <= 1'h0;
                bclk_s2_q[s] <= 1'h0;
                ws_s1_q[s]   <= 1'h0;
                ws_s2_q[s]   <= 1'h0;
            end else begin
                bclk_s1_q[s] <= bclk_pin[s];
                bclk_s2_q[s] <= bclk_s1_q[s];
                ws_s1_q[s]   <= ws_pin[s];
                ws_s2_q[s]   <= ws_s1_q[s];
            end
        end

        // Master bit clock and word select; word select flips on a falling edge
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                div_q[s]   <= '0;
                mcnt_q[s]  <= '0;
                mbclk_q[s] <= 1'h0;
                mws_q[s]   <= 1'h0;
            end else if (!(act_q[s] && mst[s])) begin
                div_q[s]   <= '0;
                mcnt_q[s]  <= '0;
                mbclk_q[s] <= 1'h0;
                mws_q[s]   <= 1'h0;
            end else if (div_q[s] == `AS_DIV_LAST) begin
                div_q[s]   <= '0;
                mbclk_q[s] <= ~mbclk_q[s];
                if (mbclk_q[s]) begin
                    if (mcnt_q[s] == `AS_WORD_LAST) begin
                        mcnt_q[s] <= '0;
                        mws_q[s]  <= ~mws_q[s];
                    end else begin
                        mcnt_q[s] <= mcnt_q[s] + `AS_CNT_ONE;
                    end
                end
            end else begin
                div_q[s] <= div_q[s] + `AS_DIV_W'(1);
            end
        end

        // Slave pins are ignored while their input buffer is off
        assign bclk_now[s] = mst[s] ? mbclk_q[s] : (bclk_s2_q[s] & act_q[s]);
        assign ws_now[s]   = mst[s] ? mws_q[s]   : (ws_s2_q[s] & act_q[s]);

        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                bclk_prev_q[s] <= 1'h0;
                ws_last_q[s]   <= 1'h0;
            end else if (!act_q[s]) begin
                bclk_prev_q[s] <= 1'h0;
                ws_last_q[s]   <= 1'h0;
            end else begin
                bclk_prev_q[s] <= bclk_now[s];
                if (fall[s]) begin
                    ws_last_q[s] <= ws_now[s];
                end
            end
        end

        // Gated by activity, since the edge flop lags a section just switched off
        assign rise[s]  = act_q[s] & bclk_now[s] & ~bclk_prev_q[s];
        assign fall[s]  = act_q[s] & ~bclk_now[s] & bclk_prev_q[s];
        // A word begins at the falling edge where word select has moved
        assign start[s] = fall[s] & (ws_now[s] != ws_last_q[s]);
    end

    assign rx_bit_clock_o   = mbclk_q[`AS_RX];
    assign rx_word_select_o = mws_q[`AS_RX];
    assign tx_bit_clock_o   = mbclk_q[`AS_TX];
    assign tx_word_select_o = mws_q[`AS_TX];

    // ------------------------------------------------------------------
    // Receivers: sample on rising edge, hand over at next word start
    // ------------------------------------------------------------------
    logic [1:0]  dat_s1_q;
    logic [1:0]  dat_s2_q;
    logic [1:0]  dat_pin;
    sample_type  rx_sh_q [2];
    bit_cnt_type rx_cnt_q;
    logic        rx_pend_q;
    logic        rx_push;
    logic        buf_in_ready;
    logic        rx_overrun_q;
    logic [`AS_BUF_W-1:0] buf_out;

    assign dat_pin = {rx_data_in_1_i, rx_data_in_0_i};

    for (genvar r = 0; r < 2; r++) begin : g_rx
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                dat_s1_q[r] <= 1'h0;
                dat_s2_q[r] <= 1'h0;
                rx_sh_q[r]  <= '0;
            end else begin
                dat_s1_q[r] <= dat_pin[r];
                dat_s2_q[r] <= dat_s1_q[r];
                if (rise[`AS_RX]) begin
                    rx_sh_q[r] <= {rx_sh_q[r][`AS_WORD_BITS-2:0], dat_s2_q[r] & rx_dat_ie_q[r]};
                end
            end
        end
    end

    // Only a complete word is handed over; short frames are dropped
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_cnt_q  <= '0;
            rx_pend_q <= 1'h0;
        end else if (!act_q[`AS_RX]) begin
            rx_cnt_q  <= '0;
            rx_pend_q <= 1'h0;
        end else begin
            if (start[`AS_RX]) begin
                rx_pend_q <= 1'h1;
            end else if (rise[`AS_RX]) begin
                rx_pend_q <= 1'h0;
            end
            if (rise[`AS_RX]) begin
                if (rx_pend_q) begin
                    rx_cnt_q <= `AS_CNT_ONE;
                end else if (rx_cnt_q != `AS_CNT_FULL) begin
                    rx_cnt_q <= rx_cnt_q + `AS_CNT_ONE;
                end
            end
        end
    end

    assign rx_push = rise[`AS_RX] & rx_pend_q & (rx_cnt_q == `AS_CNT_FULL);

    // The serial clock cannot be stalled, so a full buffer can only flag loss
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_overrun_q <= 1'h0;
        end else begin
            rx_overrun_q <= (rx_push & ~buf_in_ready) | (rx_overrun_q & ~sw_reset);
        end
    end

    sample_buffer #(
        .WIDTH (`AS_BUF_W),
        .DEPTH (`AS_BUF_DEPTH)
    ) u_rx_buffer (
        .clk       (clk),
        .rst_b     (rst_b),
        .flush     (sw_reset),
        .in_valid  (rx_push),
        .in_ready  (buf_in_ready),
        .in_data   ({~ws_last_q[`AS_RX], rx_sh_q[1], rx_sh_q[0]}),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (buf_out)
    );

    assign rx_right    = buf_out[`AS_BUF_W-1];
    assign rx_sample_1 = buf_out[2*`AS_WORD_BITS-1:`AS_WORD_BITS];
    assign rx_sample_0 = buf_out[`AS_WORD_BITS-1:0];
    assign rx_overrun  = rx_overrun_q;

    // ------------------------------------------------------------------
    // Transmitters: hold register, shift on falling edge
    // ------------------------------------------------------------------
    sample_type tx_hold_q;
    logic       tx_full_q;
    sample_type tx_sh_q;
    logic       tx_load;
    logic       tx_take;
    logic       tx_underrun_q;
    logic [2:0] tx_out_q;

    assign tx_ready = ~tx_full_q;
    assign tx_take  = tx_valid & ~tx_full_q;
    assign tx_load  = start[`AS_TX];

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_hold_q <= '0;
            tx_full_q <= 1'h0;
        end else if (sw_reset) begin
            tx_full_q <= 1'h0;
        end else begin
            if (tx_take) begin
                tx_hold_q <= tx_sample;
            end
            tx_full_q <= tx_take | (tx_full_q & ~tx_load);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_sh_q <= `AS_TX_IDLE;
        end else if (!act_q[`AS_TX]) begin
            tx_sh_q <= `AS_TX_IDLE;
        end else if (tx_load) begin
            tx_sh_q <= tx_full_q ? tx_hold_q : `AS_TX_IDLE;
        end else if (fall[`AS_TX]) begin
            tx_sh_q <= {tx_sh_q[`AS_WORD_BITS-2:0], 1'h1};
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_underrun_q <= 1'h0;
        end else begin
            tx_underrun_q <= (tx_load & ~tx_full_q) | (tx_underrun_q & ~sw_reset);
        end
    end

    // Disabled transmitters idle high, as they do through reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_out_q <= 3'h7;
        end else begin
            tx_out_q <= ~tx_on_q | {3{tx_sh_q[`AS_WORD_BITS-1]}};
        end
    end

    assign tx_data_out_0 = tx_out_q[0];
    assign tx_data_out_1 = tx_out_q[1];
    assign tx_data_out_2 = tx_out_q[2];
    assign tx_underrun   = tx_underrun_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence rx_blocked_s;
        sw_reset || stop_state;
    endsequence

    sequence tx_clk_edge_s;
        $changed(tx_bit_clock_o) ##0 tx_bit_clock_oe;
    endsequence

    rx_data0_hiz_a:
        assert property ((blocked || !rx0_enable_bit) |=> !rx_data_in_0_ie)
        else $error("receive data 0 input buffer on while it should float");
    rx_data1_hiz_a:
        assert property ((sw_reset || stop_state || !rx1_enable_bit) |=> !rx_data_in_1_ie)
        else $error("receive data 1 input buffer on while it should float");
    rx_clk_dir_a:
        assert property ((!blocked && rx0_enable_bit) |=> (rx_bit_clock_oe == $past(rx_master)))
        else $error("receive bit clock direction does not follow its own master setting");
    rx_clk_hiz_a:
        assert property ((!rx0_enable_bit && !rx1_enable_bit) |=> (!rx_bit_clock_oe && !rx_bit_clock_ie))
        else $error("receive bit clock not floating with receivers off");
    rx_ws_dir_a:
        assert property (rx_word_select_oe |-> (rx_bit_clock_oe && $past(rx_master)))
        else $error("receive word select driven outside master mode");
    rx_ws_frame_a:
        assert property (($changed(rx_word_select_o) && rx_word_select_oe && $past(rx_word_select_oe))
                         |-> $fell(rx_bit_clock_o))
        else $error("receive word select moved away from a falling bit clock");
    rx_ws_hiz_a:
        assert property (rx_blocked_s |=> (!rx_word_select_oe && !rx_word_select_ie))
        else $error("receive word select not floating in reset or stop");
    tx_data0_high_a:
        assert property ((!tx0_enable_bit || sw_reset || stop_state) |=> ##1 tx_data_out_0)
        else $error("transmit data 0 not high while disabled");
    tx_data1_high_a:
        assert property ((!tx1_enable_bit || sw_reset || stop_state) |=> ##1 tx_data_out_1)
        else $error("transmit data 1 not high while disabled");
    tx_data2_high_a:
        assert property ((!tx2_enable_bit || sw_reset || stop_state) |=> ##1 tx_data_out_2)
        else $error("transmit data 2 not high while disabled");
    tx_clk_dir_a:
        assert property ((!blocked && tx1_enable_bit) |=> (tx_bit_clock_oe == $past(tx_master)))
        else $error("transmit bit clock direction does not follow its own master setting");
    tx_clk_half_a:
        assert property (tx_clk_edge_s |=> ($stable(tx_bit_clock_o) || !tx_bit_clock_oe)[*3])
        else $error("transmit master bit clock half period too short");
    tx_clk_hiz_a:
        assert property ((sw_reset || stop_state) |=> (!tx_bit_clock_oe && !tx_bit_clock_ie))
        else $error("transmit bit clock not floating in reset or stop");
    tx_ws_frame_a:
        assert property (($changed(tx_word_select_o) && tx_word_select_oe && $past(tx_word_select_oe))
                         |-> $fell(tx_bit_clock_o))
        else $error("transmit word select moved away from a falling bit clock");
    tx_ws_hiz_a:
        assert property ((!tx0_enable_bit && !tx1_enable_bit && !tx2_enable_bit) |=> !tx_word_select_oe)
        else $error("transmit word select driven with transmitters off");
    rx_buf_off_a:
        assert property ((!rx_bit_clock_ie && !rx_master) |-> (!rise[`AS_RX] && !fall[`AS_RX]))
        else $error("floating receive clock pin reached internal logic");

endmodule // audio_serial_port

// ### dv/audio_codec_model.sv
// Codec-side model: clock master for the slave sections of the port.
// Assumes run is a level from the bench; the bit clock stands still when low.
module audio_codec_model (
    input  wire logic        run,
    input  wire logic [15:0] word,
    input  wire logic        sdo,
    output logic             bclk,
    output logic             ws,
    output logic             sd0,
    output logic             sd1,
    output logic      [15:0] heard
);
    timeunit 1ns;
    timeprecision 100ps;
    int bit_n = 0;
    logic [15:0] sh;
    initial begin
        bclk = 1'b0;
        ws = 1'b0;
        sd0 = 1'b0;
        sd1 = 1'b1;
    end
    // Half period of 32 ns gives the 64 ns link clock
    always #32 begin
        if (!run) begin
            // Idle data keeps moving so a stale level never looks valid
            sd0 <= ~sd0;
            sd1 <= ~sd1;
        end else if (bclk) begin
            bclk <= 1'b0;
            if (bit_n == 0) begin
                ws <= ~ws;
                // A word ends where word select moves; keep what was heard
                heard <= sh;
            end
            sd0 <= word[15 - bit_n];
            sd1 <= ~word[15 - bit_n];
            bit_n <= (bit_n + 1) % 16;
        end else begin
            bclk <= 1'b1;
            sh <= {sh[14:0], sdo};
        end
    end
endmodule // audio_codec_model

// ### dv/tb_audio_serial_port.sv
// Bench for the audio serial port: pin states and a slave-mode stream.
// Assumes the codec model clocks both slave sections.
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
    fails++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb_audio_serial_port
    import audio_serial_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst_b = 0, sw_reset = 0, stop_state = 0, rx_master = 0, tx_master = 0;
    logic run = 0, rx_ready = 0, tx_valid = 0, bclk, ws, sd0, sd1;
    logic [4:0] en = 5'h00;
    sample_type rx_sample_0, rx_sample_1, heard, tx_sample = 16'h0000;
    logic rx_data_in_0_ie, rx_data_in_1_ie, rx_bit_clock_o, rx_bit_clock_oe, rx_bit_clock_ie;
    logic rx_word_select_o, rx_word_select_oe, rx_word_select_ie, tx_data_out_0, tx_data_out_1;
    logic tx_data_out_2, tx_bit_clock_o, tx_bit_clock_oe, tx_bit_clock_ie, tx_word_select_o;
    logic tx_word_select_oe, tx_word_select_ie, rx_right, rx_valid, rx_overrun, tx_ready, tx_underrun;
    int fails = 0, n_compared = 0;
    wire [12:0] pins = {rx_data_in_0_ie, rx_data_in_1_ie, rx_bit_clock_oe, rx_bit_clock_ie,
        rx_word_select_oe, rx_word_select_ie, tx_bit_clock_oe, tx_bit_clock_ie, tx_word_select_oe,
        tx_word_select_ie, tx_data_out_0, tx_data_out_1, tx_data_out_2};
    always #2.5 clk = ~clk;
    // The three outputs are merged so that one wrong transmitter spoils the heard word
    audio_codec_model codec_u (.run(run), .word(16'ha5c3),
        .sdo(tx_data_out_0 ^ tx_data_out_1 ^ tx_data_out_2),
        .bclk(bclk), .ws(ws), .sd0(sd0), .sd1(sd1), .heard(heard));
    audio_serial_port dut_u (.clk(clk), .rst_b(rst_b), .sw_reset(sw_reset), .stop_state(stop_state),
        .rx_master(rx_master), .tx_master(tx_master), .rx0_enable_bit(en[0]), .rx1_enable_bit(en[1]),
        .tx0_enable_bit(en[2]), .tx1_enable_bit(en[3]), .tx2_enable_bit(en[4]), .rx_data_in_0_i(sd0),
        .rx_data_in_0_ie(rx_data_in_0_ie), .rx_data_in_1_i(sd1), .rx_data_in_1_ie(rx_data_in_1_ie),
        .rx_bit_clock_i(bclk), .rx_bit_clock_o(rx_bit_clock_o), .rx_bit_clock_oe(rx_bit_clock_oe),
        .rx_bit_clock_ie(rx_bit_clock_ie), .rx_word_select_i(ws), .rx_word_select_o(rx_word_select_o),
        .rx_word_select_oe(rx_word_select_oe), .rx_word_select_ie(rx_word_select_ie),
        .tx_data_out_0(tx_data_out_0), .tx_data_out_1(tx_data_out_1), .tx_data_out_2(tx_data_out_2),
        .tx_bit_clock_i(bclk), .tx_bit_clock_o(tx_bit_clock_o), .tx_bit_clock_oe(tx_bit_clock_oe),
        .tx_bit_clock_ie(tx_bit_clock_ie), .tx_word_select_i(ws), .tx_word_select_o(tx_word_select_o),
        .tx_word_select_oe(tx_word_select_oe), .tx_word_select_ie(tx_word_select_ie),
        .rx_sample_0(rx_sample_0), .rx_sample_1(rx_sample_1), .rx_right(rx_right), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_overrun(rx_overrun), .tx_sample(tx_sample), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_underrun(tx_underrun));
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic cfg(input logic rm, tm, input logic [4:0] e, input logic st, sr);
        rx_master = rm;
        tx_master = tm;
        en = e;
        stop_state = st;
        sw_reset = sr;
        step(3);
    endtask
    task automatic master_stream();
        int n = 0;
        logic last;
        cfg(1, 1, 5'h1f, 0, 0);
        last = rx_bit_clock_o;
        // Half period of four clocks gives sixteen bit clock edges in 64 cycles
        repeat (64) begin
            step(1);
            if (rx_bit_clock_o != last) n++;
            last = rx_bit_clock_o;
        end
        `CHK("rx master bit clock edges", 32'h0000_0010, n)
        // Word select moves after sixteen bit periods of eight clocks
        step(70);
        `CHK("master word selects", 2'b11, {rx_word_select_o, tx_word_select_o})
    endtask
    task automatic master_modes();
        cfg(1, 0, 5'h1f, 0, 0);
        `CHK("rx master pins", 13'h1faf, pins)
        cfg(0, 1, 5'h1f, 0, 0);
        `CHK("tx master pins", 13'h1aff, pins)
        cfg(0, 1, 5'h1e, 0, 0);
        `CHK("rx0 off pins", 13'h0aff, pins)
        cfg(0, 1, 5'h1c, 0, 0);
        `CHK("rx off pins", 13'h007f, pins)
        cfg(1, 0, 5'h03, 0, 0);
        `CHK("tx off pins", 13'h1f87, pins)
        cfg(1, 1, 5'h1f, 1, 0);
        `CHK("stop pins", 13'h0007, pins)
        cfg(1, 1, 5'h1f, 0, 1);
        `CHK("sw reset pins", 13'h0007, pins)
    endtask
    task automatic slave_stream();
        int i;
        cfg(0, 0, 5'h1f, 0, 0);
        tx_sample = 16'h1234;
        tx_valid = 1;
        step(1);
        tx_valid = 0;
        `CHK("tx hold taken", 1'b0, tx_ready)
        `CHK("no underrun", 1'b0, tx_underrun)
        run = 1;
        for (i = 0; i < 2000 && !rx_valid; i++) step(1);
        `CHK("rx word 0", 16'ha5c3, rx_sample_0)
        `CHK("rx word 1", 16'h5a3c, rx_sample_1)
        `CHK("tx hold loaded", 1'b1, tx_ready)
        `CHK("rx right word", 1'b1, rx_right)
        `CHK("tx word heard", 16'h1234, heard)
        `CHK("tx underrun", 1'b1, tx_underrun)
        // Consumer stalls for three word periods so the buffer must refuse
        step(700);
        `CHK("rx overrun", 1'b1, rx_overrun)
        run = 0;
        rx_ready = 1;
        step(4);
        `CHK("rx drained", 1'b0, rx_valid)
        rx_ready = 0;
    endtask
    task automatic results();
        $display("compared %0d failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        step(8);
        `CHK("reset pins", 13'h0007, pins)
        step(8);
        rst_b = 1;
        step(2);
        master_stream();
        master_modes();
        slave_stream();
        results();
    end
    initial begin
        #40000;
        fails++;
        results();
    end
endmodule // tb_audio_serial_port
